// ### rtl/aclq_pkg.sv
// constants, offsets and types for the access-control rule qualifier
package aclq_pkg;

  // ----------------------------------------------------------------
  // register map of the byte register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ACLQ_ADDR_IND_CTRL = 8'h6e;
  localparam logic [7:0] ACLQ_ADDR_IND_ADDR = 8'h6f;
  localparam logic [7:0] ACLQ_ADDR_IND_DATA = 8'ha0;
  localparam logic [2:0] ACLQ_TABLE_ACL = 3'h2;
  localparam int ACLQ_TABLE_MSB = 7;
  localparam int ACLQ_TABLE_LSB = 5;
  localparam int ACLQ_PORT_MSB = 3;
  localparam logic [7:0] ACLQ_OFS_MODE = 8'h01;
  localparam logic [7:0] ACLQ_OFS_MAC_FIRST = 8'h02;
  localparam logic [7:0] ACLQ_IND_CTRL_RST = 8'h00;
  localparam logic [7:0] ACLQ_IND_ADDR_RST = 8'h00;
  localparam logic [7:0] ACLQ_MODE_RST = 8'h00;
  localparam logic [7:0] ACLQ_MAC_FIRST_RST = 8'h00;
  localparam logic [7:0] ACLQ_MODE_RW_MASK = 8'h3f;

  // ----------------------------------------------------------------
  // fields of the rule mode qualifier byte
  // ----------------------------------------------------------------
  localparam int ACLQ_LAYER_MSB = 5;
  localparam int ACLQ_LAYER_LSB = 4;
  localparam int ACLQ_CODE_MSB = 3;
  localparam int ACLQ_CODE_LSB = 2;
  localparam int ACLQ_SRC_SEL_BIT = 1;
  localparam int ACLQ_POL_BIT = 0;

  typedef enum logic [1:0] {
    ACLQ_LAYER_OFF = 2'b00,
    ACLQ_LAYER_L2 = 2'b01,
    ACLQ_LAYER_L3 = 2'b10,
    ACLQ_LAYER_L4 = 2'b11
  } aclq_layer_t;

  localparam logic [1:0] ACLQ_CODE_00 = 2'b00;
  localparam logic [1:0] ACLQ_CODE_01 = 2'b01;
  localparam logic [1:0] ACLQ_CODE_10 = 2'b10;
  localparam logic [1:0] ACLQ_CODE_11 = 2'b11;

  // ----------------------------------------------------------------
  // timing of the packet-rate counter
  // ----------------------------------------------------------------
  localparam int ACLQ_CLK_PERIOD_NS = 10;
  localparam int ACLQ_US_NS = 1000;
  localparam int ACLQ_US_CYCLES = ACLQ_US_NS / ACLQ_CLK_PERIOD_NS;
  localparam int ACLQ_MS_US = 1000;
  localparam int ACLQ_CNT_W = 11;
  localparam logic [ACLQ_CNT_W-1:0] ACLQ_CNT_RST = 11'h000;

endpackage

// ### rtl/aclq_rule_qualifier.sv
// per-port access-control rule qualification with packet-rate counter
//
// Contract
// - layer 00 disables rule, 01 selects layer 2
// - layer 2 code 00 counts matching packets
// - unit bit 4: clear microseconds, set milliseconds
// - bit 3 clear: load, count down, expire interrupt
// - bit 3 set: count packets, terminal interrupt, reset
// - layer 2 codes: address, type, or both
// - layer 3 code 01: masked address or protocol
// - layer 3 code 10: compare source with destination
// - layer 4: protocol, port, port, sequence number
// - direction bit clear compares destination, reset 0
// - direction bit set compares source address
// - polarity clear: differ matches; set: equal matches
`timescale 1ns/1ps
`default_nettype none

module aclq_rule_qualifier
  import aclq_pkg::*;
#(
  parameter int NUM_PORTS = 5
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic [10:0] count_value,
  input wire logic fwd_unit_ms,
  input wire logic fwd_count_up,
  input wire logic [39:0] rule_mac_low,
  input wire logic [15:0] rule_type,
  input wire logic [31:0] rule_ip,
  input wire logic [31:0] rule_ip_mask,
  input wire logic [7:0] rule_proto,
  input wire logic [15:0] rule_l4_port,
  input wire logic [31:0] rule_tcp_seq,
  input wire logic pkt_valid,
  input wire logic [3:0] pkt_port,
  input wire logic [47:0] pkt_da,
  input wire logic [47:0] pkt_sa,
  input wire logic [15:0] pkt_type,
  input wire logic [31:0] pkt_ip_sa,
  input wire logic [31:0] pkt_ip_da,
  input wire logic [7:0] pkt_proto,
  input wire logic [15:0] pkt_sport,
  input wire logic [15:0] pkt_dport,
  input wire logic [31:0] pkt_tcp_seq,
  output logic match_valid_q,
  output logic match_q,
  output logic rate_irq_q
);

  // ----------------------------------------------------------------
  // register port and indirect rule storage
  // ----------------------------------------------------------------
  logic [7:0] ind_ctrl_q;
  logic [7:0] ind_addr_q;
  logic [7:0] mode_q [NUM_PORTS];
  logic [7:0] mac_first_q [NUM_PORTS];

  // port number outside 1..NUM_PORTS selects nothing
  function automatic logic port_ok(input logic [3:0] p);
    return (p >= 4'h1) && (p <= 4'(NUM_PORTS));
  endfunction

  wire [3:0] ind_port = ind_ctrl_q[ACLQ_PORT_MSB:0];
  wire [2:0] ind_idx = 3'(ind_port - 4'h1);
  wire ind_acl = (ind_ctrl_q[ACLQ_TABLE_MSB:ACLQ_TABLE_LSB] == ACLQ_TABLE_ACL);
  wire ind_ok = ind_acl && port_ok(ind_port);
  wire data_wr = reg_wr && (reg_addr == ACLQ_ADDR_IND_DATA) && ind_ok;
  wire wr_mode = data_wr && (ind_addr_q == ACLQ_OFS_MODE);
  wire wr_mac = data_wr && (ind_addr_q == ACLQ_OFS_MAC_FIRST);
  wire [7:0] ind_rdata = !ind_ok ? 8'h00 :
                         (ind_addr_q == ACLQ_OFS_MODE) ? (mode_q[ind_idx] & ACLQ_MODE_RW_MASK) :
                         (ind_addr_q == ACLQ_OFS_MAC_FIRST) ? mac_first_q[ind_idx] : 8'h00;
  wire [7:0] rd_mux = (reg_addr == ACLQ_ADDR_IND_CTRL) ? ind_ctrl_q :
                      (reg_addr == ACLQ_ADDR_IND_ADDR) ? ind_addr_q :
                      (reg_addr == ACLQ_ADDR_IND_DATA) ? ind_rdata : 8'h00;

  // direct control registers; read data follows a read strobe by one cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ind_ctrl_q <= ACLQ_IND_CTRL_RST;
      ind_addr_q <= ACLQ_IND_ADDR_RST;
      reg_rdata_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == ACLQ_ADDR_IND_CTRL) ind_ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == ACLQ_ADDR_IND_ADDR) ind_addr_q <= reg_wdata;
      if (reg_rd) reg_rdata_q <= rd_mux;
    end
  end

  // rule bytes per port; reserved mode bits never store
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        mode_q[i] <= ACLQ_MODE_RST;
        mac_first_q[i] <= ACLQ_MAC_FIRST_RST;
      end
    end else begin
      if (wr_mode) mode_q[ind_idx] <= reg_wdata & ACLQ_MODE_RW_MASK;
      if (wr_mac) mac_first_q[ind_idx] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // field selection and comparison for the packet's ingress port
  // ----------------------------------------------------------------
  wire pkt_ok = port_ok(pkt_port);
  wire [2:0] pkt_idx = 3'(pkt_port - 4'h1);
  wire [7:0] pmode = pkt_ok ? mode_q[pkt_idx] : ACLQ_MODE_RST;
  wire [1:0] layer = pmode[ACLQ_LAYER_MSB:ACLQ_LAYER_LSB];
  wire [1:0] en_code = pmode[ACLQ_CODE_MSB:ACLQ_CODE_LSB];
  wire use_src = pmode[ACLQ_SRC_SEL_BIT];
  wire pol_eq = pmode[ACLQ_POL_BIT];
  wire [47:0] ref_mac = {(pkt_ok ? mac_first_q[pkt_idx] : 8'h00), rule_mac_low};

  wire [47:0] sel_mac = use_src ? pkt_sa : pkt_da;
  wire [31:0] sel_ip = use_src ? pkt_ip_sa : pkt_ip_da;
  wire [15:0] sel_l4 = use_src ? pkt_sport : pkt_dport;

  wire eq_mac = (sel_mac == ref_mac);
  wire eq_type = (pkt_type == rule_type);
  wire eq_proto = (pkt_proto == rule_proto);
  // zero mask means the protocol is tested instead of the address
  wire eq_ip = (rule_ip_mask != 32'h0) ? ((sel_ip & rule_ip_mask) == (rule_ip & rule_ip_mask))
                                       : eq_proto;

  logic cmp_eq;
  logic cmp_valid;

  // decision per layer and enable code
  always_comb begin
    cmp_eq = 1'b0;
    cmp_valid = 1'b0;
    case (aclq_layer_t'(layer))
      ACLQ_LAYER_OFF: cmp_valid = 1'b0;
      ACLQ_LAYER_L2: begin
        cmp_valid = 1'b1;
        case (en_code)
          ACLQ_CODE_01: cmp_eq = eq_mac;
          ACLQ_CODE_10: cmp_eq = eq_type;
          default: cmp_eq = eq_mac && eq_type;
        endcase
      end
      ACLQ_LAYER_L3: begin
        cmp_valid = (en_code == ACLQ_CODE_01) || (en_code == ACLQ_CODE_10);
        cmp_eq = (en_code == ACLQ_CODE_10) ? (pkt_ip_sa == pkt_ip_da) : eq_ip;
      end
      ACLQ_LAYER_L4: begin
        cmp_valid = 1'b1;
        case (en_code)
          ACLQ_CODE_00: cmp_eq = eq_proto;
          ACLQ_CODE_11: cmp_eq = (pkt_tcp_seq == rule_tcp_seq);
          default: cmp_eq = (sel_l4 == rule_l4_port);
        endcase
      end
      default: cmp_valid = 1'b0;
    endcase
  end

  wire match_d = cmp_valid && (pol_eq ? cmp_eq : !cmp_eq);

  // one result per packet, one cycle after it is offered
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      match_valid_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      match_valid_q <= pkt_valid;
      match_q <= pkt_valid && match_d;
    end
  end

  // ----------------------------------------------------------------
  // time base: microsecond and millisecond enable pulses
  // ----------------------------------------------------------------
  logic [6:0] us_div_q;
  logic [9:0] ms_div_q;
  wire us_tick = (us_div_q == 7'(ACLQ_US_CYCLES - 1));
  wire ms_tick = us_tick && (ms_div_q == 10'(ACLQ_MS_US - 1));
  wire unit_tick = fwd_unit_ms ? ms_tick : us_tick;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      us_div_q <= 7'h00;
      ms_div_q <= 10'h000;
    end else begin
      us_div_q <= us_tick ? 7'h00 : us_div_q + 7'h01;
      if (us_tick) ms_div_q <= (ms_div_q == 10'(ACLQ_MS_US - 1)) ? 10'h000 : ms_div_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // packet-rate counters, one per port
  // ----------------------------------------------------------------
  logic [ACLQ_CNT_W-1:0] cnt_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] armed_q;
  logic [NUM_PORTS-1:0] fire;
  logic [NUM_PORTS-1:0] qual;

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      qual[i] = pkt_valid && pkt_ok && (pkt_idx == 3'(i)) && (layer == ACLQ_LAYER_L2)
                && (en_code == ACLQ_CODE_00) && eq_mac && eq_type;
      if (fwd_count_up) begin
        fire[i] = qual[i] && (cnt_q[i] + 11'h001 >= count_value);
      end else begin
        fire[i] = armed_q[i] && !qual[i] && unit_tick && (cnt_q[i] <= 11'h001);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      armed_q <= '0;
      for (int i = 0; i < NUM_PORTS; i++) cnt_q[i] <= ACLQ_CNT_RST;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (fwd_count_up) begin
          armed_q[i] <= 1'b0;
          if (qual[i]) cnt_q[i] <= fire[i] ? ACLQ_CNT_RST : cnt_q[i] + 11'h001;
        end else if (qual[i]) begin
          cnt_q[i] <= count_value;
          armed_q[i] <= 1'b1;
        end else if (armed_q[i] && unit_tick) begin
          cnt_q[i] <= fire[i] ? ACLQ_CNT_RST : cnt_q[i] - 11'h001;
          if (fire[i]) armed_q[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt is high one cycle after each cycle in which any port expires or reaches terminal count
  always_ff @(posedge clock) begin
    if (!reset_n) rate_irq_q <= 1'b0;
    else rate_irq_q <= |fire;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_disabled_no_match;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && layer == ACLQ_LAYER_OFF |=> match_valid_q && !match_q;
  endproperty
  a_disabled_no_match: assert property (p_disabled_no_match) else $error("disabled rule matched");

  property p_polarity;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && cmp_valid |=> match_q == $past(pol_eq == cmp_eq);
  endproperty
  a_polarity: assert property (p_polarity) else $error("match polarity wrong");

  property p_l2_type_only;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && layer == ACLQ_LAYER_L2 && en_code == ACLQ_CODE_10 && pol_eq && eq_type
      |=> match_q;
  endproperty
  a_l2_type_only: assert property (p_l2_type_only) else $error("type-only test failed");

  property p_l3_reserved;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && layer == ACLQ_LAYER_L3 && (en_code == ACLQ_CODE_00 || en_code == ACLQ_CODE_11)
      |=> !match_q;
  endproperty
  a_l3_reserved: assert property (p_l3_reserved) else $error("reserved code matched");

  property p_l3_sa_da;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && layer == ACLQ_LAYER_L3 && en_code == ACLQ_CODE_10 && pol_eq
      |=> match_q == $past(pkt_ip_sa == pkt_ip_da);
  endproperty
  a_l3_sa_da: assert property (p_l3_sa_da) else $error("address pair compare wrong");

  property p_src_select;
    @(posedge clock) disable iff (!reset_n)
      pkt_valid && layer == ACLQ_LAYER_L4 && en_code == ACLQ_CODE_01 && use_src && pol_eq
      |=> match_q == $past(pkt_sport == rule_l4_port);
  endproperty
  a_src_select: assert property (p_src_select) else $error("source port not used");

  property p_tick_period;
    @(posedge clock) disable iff (!reset_n)
      us_tick |=> !us_tick [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("microsecond tick too fast");

  property p_down_reload;
    @(posedge clock) disable iff (!reset_n)
      !fwd_count_up && qual[0] |=> cnt_q[0] == $past(count_value) && armed_q[0];
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("counter not reloaded");

  property p_irq_on_fire;
    @(posedge clock) disable iff (!reset_n)
      fire[0] |=> rate_irq_q && cnt_q[0] == ACLQ_CNT_RST;
  endproperty
  a_irq_on_fire: assert property (p_irq_on_fire) else $error("interrupt or reset missing");

  property p_up_count;
    @(posedge clock) disable iff (!reset_n)
      fwd_count_up && qual[0] && !fire[0] |=> cnt_q[0] == $past(cnt_q[0]) + 11'h001;
  endproperty
  a_up_count: assert property (p_up_count) else $error("up count did not step");

  property p_count_only_l2;
    @(posedge clock) disable iff (!reset_n)
      qual[0] |-> layer == ACLQ_LAYER_L2 && en_code == ACLQ_CODE_00;
  endproperty
  a_count_only_l2: assert property (p_count_only_l2) else $error("counted outside mode");

endmodule // aclq_rule_qualifier

`default_nettype wire

// ### tb/aclq_frame_src.sv
// ingress header source model standing in for the switch ports
`timescale 1ns/1ps
`default_nettype none

module aclq_frame_src (
  input wire logic clock,
  output logic pkt_valid,
  output logic [3:0] pkt_port,
  output logic [47:0] pkt_da,
  output logic [47:0] pkt_sa,
  output logic [15:0] pkt_type,
  output logic [31:0] pkt_ip_sa,
  output logic [31:0] pkt_ip_da,
  output logic [7:0] pkt_proto,
  output logic [15:0] pkt_sport,
  output logic [15:0] pkt_dport,
  output logic [31:0] pkt_tcp_seq
);
  // ------------------------------------------------------------------
  // header driver
  // ------------------------------------------------------------------
  logic [251:0] hdr_q;

  // all header fields travel as one vector to keep the driver short
  assign {pkt_port, pkt_da, pkt_sa, pkt_type, pkt_ip_sa, pkt_ip_da, pkt_proto, pkt_sport,
    pkt_dport, pkt_tcp_seq} = hdr_q;

  initial begin
    pkt_valid = 1'b0;
    hdr_q = '0;
  end

  // one header per call; fields flip afterwards so stale values never pass as a header
  task automatic send(input logic [3:0] p, input logic [247:0] f);
    @(posedge clock);
    pkt_valid <= 1'b1;
    hdr_q <= {p, f};
    @(posedge clock);
    pkt_valid <= 1'b0;
    hdr_q <= ~{p, f};
  endtask
endmodule // aclq_frame_src

`default_nettype wire

// ### tb/tb_aclq_rule_qualifier.sv
// self-checking testbench for the access-control rule qualifier
`timescale 1ns/1ps
`default_nettype none

module tb_aclq_rule_qualifier
  import aclq_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [47:0] MAC_HIT = 48'haa1122334455;
  logic clock, reset_n, reg_wr, reg_rd, fwd_unit_ms, fwd_count_up, pkt_valid;
  logic match_valid_q, match_q, rate_irq_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rule_proto, pkt_proto;
  logic [10:0] count_value;
  logic [39:0] rule_mac_low;
  logic [15:0] rule_type, rule_l4_port, pkt_type, pkt_sport, pkt_dport;
  logic [31:0] rule_ip, rule_ip_mask, rule_tcp_seq, pkt_ip_sa, pkt_ip_da, pkt_tcp_seq;
  logic [3:0] pkt_port, port;
  logic [47:0] pkt_da, pkt_sa;
  int fails = 0;
  int checks_done = 0;
  int irqs = 0;

  aclq_rule_qualifier aclq_rule_qualifier_inst (.clock, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_q, .count_value, .fwd_unit_ms, .fwd_count_up, .rule_mac_low,
    .rule_type, .rule_ip, .rule_ip_mask, .rule_proto, .rule_l4_port, .rule_tcp_seq, .pkt_valid,
    .pkt_port, .pkt_da, .pkt_sa, .pkt_type, .pkt_ip_sa, .pkt_ip_da, .pkt_proto, .pkt_sport,
    .pkt_dport, .pkt_tcp_seq, .match_valid_q, .match_q, .rate_irq_q);

  aclq_frame_src aclq_frame_src_inst (.clock, .pkt_valid, .pkt_port, .pkt_da, .pkt_sa,
    .pkt_type, .pkt_ip_sa, .pkt_ip_da, .pkt_proto, .pkt_sport, .pkt_dport, .pkt_tcp_seq);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // interrupt pulses are counted so a missed or extra pulse shows later
  always @(posedge clock) begin
    if (rate_irq_q === 1'b1) irqs <= irqs + 1;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, e);
  endtask

  // mode byte to the port picked by the indirect control register, then one header on port with up to two fields set over a zero base;
  // field index: 0 da, 1 sa, 2 type, 3 ip sa, 4 ip da, 5 proto, 6 sport, 7 dport, 8 seq
  task automatic t(input logic [7:0] m, input int fa, input logic [47:0] va, input int fb,
    input logic [47:0] vb, input logic e);
    logic [47:0] fv [10];
    foreach (fv[i]) fv[i] = '0;
    fv[fa] = va;
    fv[fb] = vb;
    wr(ACLQ_ADDR_IND_DATA, m);
    aclq_frame_src_inst.send(port, {fv[0], fv[1], fv[2][15:0], fv[3][31:0], fv[4][31:0],
      fv[5][7:0], fv[6][15:0], fv[7][15:0], fv[8][31:0]});
    #1;
    check(match_valid_q, 1'b1);
    check(match_q, e);
  endtask

  task automatic wait_irq(input int n);
    int k;
    k = irqs;
    for (int i = 0; i < n && irqs == k; i++) @(posedge clock);
    if (irqs == k) begin
      fails++;
      end_sim();
    end
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {count_value, fwd_unit_ms, fwd_count_up} = {11'h003, 1'b0, 1'b1};
    {rule_mac_low, rule_type} = {40'h1122334455, 16'h0800};
    {rule_ip, rule_ip_mask, rule_proto} = {32'hc0a80001, 32'hffffff00, 8'h06};
    {rule_l4_port, rule_tcp_seq} = {16'h0050, 32'h12345678};
    port = 4'h1;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    check({match_valid_q, match_q, rate_irq_q}, 3'h0);
    rd(ACLQ_ADDR_IND_CTRL, 8'h00);
    rd(8'h55, 8'h00);
    wr(ACLQ_ADDR_IND_CTRL, 8'h41);
    wr(ACLQ_ADDR_IND_ADDR, 8'h02);
    rd(ACLQ_ADDR_IND_DATA, 8'h00);
    wr(ACLQ_ADDR_IND_DATA, 8'haa);
    rd(ACLQ_ADDR_IND_DATA, 8'haa);
    wr(ACLQ_ADDR_IND_ADDR, 8'h01);
    rd(ACLQ_ADDR_IND_DATA, 8'h00);
    wr(ACLQ_ADDR_IND_DATA, 8'hff);
    rd(ACLQ_ADDR_IND_DATA, 8'h3f);
    // a table code other than the rule table hides the rule bytes
    wr(ACLQ_ADDR_IND_CTRL, 8'h21);
    rd(ACLQ_ADDR_IND_DATA, 8'h00);
    wr(ACLQ_ADDR_IND_CTRL, 8'h41);
    // field selection per layer and code
    t(8'h05, 0, MAC_HIT, 9, 0, 1'b0);
    t(8'h15, 0, MAC_HIT, 9, 0, 1'b1);
    t(8'h14, 0, MAC_HIT, 9, 0, 1'b0);
    t(8'h14, 9, 0, 9, 0, 1'b1);
    t(8'h17, 0, MAC_HIT, 9, 0, 1'b0);
    t(8'h17, 1, MAC_HIT, 9, 0, 1'b1);
    t(8'h19, 2, 48'h0800, 9, 0, 1'b1);
    t(8'h1d, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    t(8'h1d, 0, MAC_HIT, 9, 0, 1'b0);
    t(8'h25, 4, 48'hc0a80077, 9, 0, 1'b1);
    t(8'h25, 4, 48'hc0a90001, 9, 0, 1'b0);
    t(8'h21, 4, 48'hc0a80077, 9, 0, 1'b0);
    t(8'h2d, 4, 48'hc0a80077, 9, 0, 1'b0);
    t(8'h27, 3, 48'hc0a80077, 9, 0, 1'b1);
    // a zero mask turns the layer 3 test into a protocol compare
    @(posedge clock);
    rule_ip_mask <= 32'h0;
    t(8'h25, 5, 48'h06, 9, 0, 1'b1);
    t(8'h25, 4, 48'hc0a80001, 9, 0, 1'b0);
    t(8'h29, 9, 0, 9, 0, 1'b1);
    t(8'h29, 3, 48'h5, 9, 0, 1'b0);
    t(8'h28, 3, 48'h5, 9, 0, 1'b1);
    t(8'h31, 5, 48'h06, 9, 0, 1'b1);
    t(8'h31, 9, 0, 9, 0, 1'b0);
    t(8'h35, 7, 48'h0050, 9, 0, 1'b1);
    t(8'h3b, 6, 48'h0050, 9, 0, 1'b1);
    t(8'h3b, 7, 48'h0050, 9, 0, 1'b0);
    t(8'h37, 6, 48'h0050, 9, 0, 1'b1);
    t(8'h3d, 8, 48'h12345678, 9, 0, 1'b1);
    t(8'h3d, 9, 0, 9, 0, 1'b0);
    // other ports keep their own disabled mode; port 6 does not exist
    port = 4'h2;
    t(8'h15, 0, MAC_HIT, 9, 0, 1'b0);
    port = 4'h6;
    t(8'h15, 0, MAC_HIT, 9, 0, 1'b0);
    // a write through port 5 lands there and leaves port 1 alone
    wr(ACLQ_ADDR_IND_CTRL, 8'h45);
    port = 4'h5;
    t(8'h31, 5, 48'h06, 9, 0, 1'b1);
    wr(ACLQ_ADDR_IND_CTRL, 8'h41);
    rd(ACLQ_ADDR_IND_DATA, 8'h15);
    port = 4'h1;
    // packet counter up to three, a type miss in between does not count
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    t(8'h11, 0, MAC_HIT, 9, 0, 1'b0);
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (5) @(posedge clock);
    check(irqs, 0);
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (3) @(posedge clock);
    check(irqs, 1);
    repeat (3) t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (3) @(posedge clock);
    check(irqs, 2);
    // down timer of 3 us, reloaded once before it can run out
    @(posedge clock);
    fwd_count_up <= 1'b0;
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (150) @(posedge clock);
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (150) @(posedge clock);
    check(irqs, 2);
    wait_irq(400);
    check(irqs, 3);
    // millisecond unit: one unit is far longer than the wait here
    @(posedge clock);
    fwd_unit_ms <= 1'b1;
    count_value <= 11'h001;
    t(8'h11, 0, MAC_HIT, 2, 48'h0800, 1'b1);
    repeat (1000) @(posedge clock);
    check(irqs, 3);
    // mid-run reset clears rule bytes and disarms the timer; a live us timer would fire soon
    @(posedge clock);
    reset_n <= 1'b0;
    fwd_unit_ms <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    check({match_valid_q, match_q, rate_irq_q}, 3'h0);
    rd(ACLQ_ADDR_IND_CTRL, 8'h00);
    wr(ACLQ_ADDR_IND_CTRL, 8'h41);
    wr(ACLQ_ADDR_IND_ADDR, 8'h01);
    rd(ACLQ_ADDR_IND_DATA, 8'h00);
    repeat (300) @(posedge clock);
    check(irqs, 3);
    end_sim();
  end
endmodule // tb_aclq_rule_qualifier

`default_nettype wire
